/* File: src/ebc_defines.svh */
`ifndef EBC_DEFINES_SVH
`define EBC_DEFINES_SVH

// ***************************************************************
// Size code values on beat_width_code
// ***************************************************************
`define EBC_SIZ_LONG   2'h0
`define EBC_SIZ_BYTE   2'h1
`define EBC_SIZ_WORD   2'h2
`define EBC_SIZ_LINE   2'h3

// ***************************************************************
// Byte counts
// ***************************************************************
`define EBC_BYTES_BYTE 5'h01
`define EBC_BYTES_WORD 5'h02
`define EBC_BYTES_LONG 5'h04
`define EBC_BYTES_LINE 5'h10

// ***************************************************************
// Reset values
// ***************************************************************
`define EBC_RST_ADDR   32'h0000_0000
`define EBC_RST_DATA   32'h0000_0000
`define EBC_RST_STROBE 1'h1
`define EBC_RST_OE     1'h0

`endif

/* File: src/ebc_pkg.sv */
package ebc_pkg;

   typedef enum logic [1:0] {
      S_IDLE,
      S_START,
      S_WAIT,
      S_HOLD
   } ebc_state_t;

   // Transfer request from the internal side
   typedef struct packed {
      logic [31:0] addr;
      logic [1:0]  size;
      logic [1:0]  port;
      logic        write;
      logic        burst_inhibit;
   } ebc_req_t;

   // Whole state of the bus master
   typedef struct packed {
      ebc_state_t  state;
      logic [31:0] addr;
      logic [4:0]  rem;
      logic [4:0]  beat;
      logic [1:0]  tsize;
      logic [1:0]  port;
      logic        write;
      logic        burst_inhibit;
      logic        misal;
      logic        first;
      logic [1:0]  siz;
      logic        ts_n;
      logic        oe;
      logic        data_oe;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic        beat_done;
      logic        xfer_done;
      logic        ready;
      logic        other_busy;
      logic [1:0]  ack_sync;
      logic [1:0]  grant_sync;
      logic [1:0]  ts_sync;
      logic [1:0]  as_sync;
      logic [31:0] din_sync1;
      logic [31:0] din_sync2;
   } ebc_master_t;

   // Whole state of the falling-edge address strobe stage
   typedef struct packed {
      logic as_n;
      logic as_oe;
   } ebc_strobe_t;

endpackage

/* File: src/ebc_as_stage.sv */
`timescale 1ns/10ps
`include "ebc_defines.svh"

module ebc_as_stage (
   input  wire logic clock_in,    // Bus clock
   input  wire logic reset_in,    // Async reset, active high
   input  wire logic ce_in,       // Clock enable
   input  wire logic as_req_in,   // Strobe wanted during cycle
   input  wire logic own_in,      // Device owns the bus
   output logic      as_n_out,    // Address strobe, active low
   output logic      as_oe_out    // Address strobe drive enable
);

   ebc_pkg::ebc_strobe_t r;
   ebc_pkg::ebc_strobe_t next_r;

   always_comb begin
      next_r       = r;
      // (RULE10) strobe moves on falling edge
      next_r.as_n  = ~as_req_in;
      // (RULE8) release strobe when not owner
      next_r.as_oe = own_in;
   end

   always_ff @(negedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         r.as_n  <= `EBC_RST_STROBE;
         r.as_oe <= `EBC_RST_OE;
      end else if (ce_in) begin
         r <= next_r;
      end
   end

   assign as_n_out  = r.as_n;
   assign as_oe_out = r.as_oe;

   // (RULE10) falling edge check
   a_as_falling_edge: assert property ( // RULE10
      @(negedge clock_in) disable iff (reset_in)
      $past(ce_in) |-> as_n_out == !$past(as_req_in))
      else $error("address strobe did not follow falling edge request");

endmodule

/* File: src/ebc_bus_master.sv */
`timescale 1ns/10ps
`include "ebc_defines.svh"

// Functional notes
// (RULE1) Misaligned longword at offset one goes byte, word, byte.
// (RULE2) Size code: 00 longword, 01 byte, 10 word, 11 line.
// (RULE3) Burst of aligned wide transfer keeps transfer size every beat.
// (RULE4) Burst-inhibited: transfer size first beat, port size after.
// (RULE5) Burst-inhibited size code updates at each transfer start.
// (RULE6) Narrow port: whole size first access, port size afterwards; code keeps whole size unless burst-inhibited or misaligned.
// (RULE7) Transfer start asserted exactly one clock when address valid.
// (RULE8) Without bus ownership, release transfer start and address strobe.
// (RULE9) Address strobe after stable address; address held while asserted.
// (RULE10) Address strobe changes only on bus clock falling edge.
// (RULE11) Cycle stays driven until transfer acknowledge is seen.
// (RULE12) Write data driven one clock after acknowledge.
// (RULE13) Peripheral holds read data until acknowledge is recognized.
// (RULE14) Acknowledge tied active only with fast termination, single master.
module ebc_bus_master (
   input  wire logic             clock_in,      // Bus clock, 25 MHz
   input  wire logic             reset_in,      // Async reset, high
   input  wire logic             ce_in,         // Clock enable
   input  wire logic             req_valid_in,  // Transfer request
   input  wire ebc_pkg::ebc_req_t req_in,       // Request attributes
   input  wire logic [31:0]      wdata_in,      // Write data per beat
   output logic                  req_ready_out, // Ready to accept request
   output logic [31:0]           rdata_out,     // Read data of beat
   output logic                  beat_done_out, // Beat finished pulse
   output logic                  xfer_done_out, // Transfer done pulse
   output logic                  other_busy_out, // Foreign cycle seen
   input  wire logic             bus_grant_in,  // Bus granted pin
   input  wire logic             transfer_acknowledge_n_in, // Ack pin
   output logic [31:0]           addr_out,      // Address pins
   output logic [1:0]            beat_width_code_out, // Size pins
   output logic                  write_out,     // High for write
   output logic                  addr_oe_out,   // Address drive enable
   output logic [31:0]           data_out,      // Data pins out
   output logic                  data_oe_out,   // Data drive enable
   input  wire logic [31:0]      data_in,       // Data pins in
   output logic                  transfer_start_strobe_n_out, // Start
   output logic                  transfer_start_strobe_oe_out, // Enable
   input  wire logic             transfer_start_strobe_n_in, // Pin in
   output logic                  address_strobe_n_out, // Strobe out
   output logic                  address_strobe_oe_out, // Enable
   input  wire logic             address_strobe_n_in  // Pin in
);

   ebc_pkg::ebc_master_t r;
   ebc_pkg::ebc_master_t next_r;
   logic                 as_req;
   logic                 ack_seen;
   logic                 grant;
   logic                 accept;
   logic [4:0]           launch_beat;
   logic [4:0]           cont_beat;
   logic [4:0]           req_bytes;
   logic [31:0]          next_addr;

   // ***************************************************************
   // Helpers
   // ***************************************************************
   // (RULE2) size code to byte count
   function automatic logic [4:0] bytes_of(input logic [1:0] code);
      logic [4:0] b;
      b = `EBC_BYTES_LONG;
      case (code)
         `EBC_SIZ_BYTE: b = `EBC_BYTES_BYTE;
         `EBC_SIZ_WORD: b = `EBC_BYTES_WORD;
         `EBC_SIZ_LINE: b = `EBC_BYTES_LINE;
         default:       b = `EBC_BYTES_LONG;
      endcase
      return b;
   endfunction

   // (RULE2) byte count of one beat to size code
   function automatic logic [1:0] code_of(input logic [4:0] b);
      logic [1:0] c;
      c = `EBC_SIZ_LONG;
      if (b == `EBC_BYTES_BYTE) begin
         c = `EBC_SIZ_BYTE;
      end else if (b == `EBC_BYTES_WORD) begin
         c = `EBC_SIZ_WORD;
      end
      return c;
   endfunction

   // (RULE1) largest beat allowed by port, alignment and remainder
   function automatic logic [4:0] beat_of(input logic [31:0] a,
                                          input logic [4:0]  rem,
                                          input logic [1:0]  port);
      logic [4:0] b;
      b = bytes_of(port);
      if (b > `EBC_BYTES_LONG) begin
         b = `EBC_BYTES_LONG;
      end
      if (a[0]) begin
         b = `EBC_BYTES_BYTE;
      end else if (a[1] && b > `EBC_BYTES_WORD) begin
         b = `EBC_BYTES_WORD;
      end
      if (rem < b) begin
         b = (rem >= `EBC_BYTES_WORD) ? `EBC_BYTES_WORD : `EBC_BYTES_BYTE;
      end
      return b;
   endfunction

   assign grant       = r.grant_sync[1];
   assign ack_seen    = ~r.ack_sync[1];
   assign as_req      = (r.state == ebc_pkg::S_START) ||
                        (r.state == ebc_pkg::S_WAIT);
   assign accept      = (r.state == ebc_pkg::S_IDLE) && req_valid_in &&
                        r.ready && grant;
   assign req_bytes   = bytes_of(req_in.size);
   assign launch_beat = beat_of(req_in.addr, req_bytes, req_in.port);
   assign next_addr   = r.addr + {27'h0, r.beat};
   assign cont_beat   = beat_of(next_addr, r.rem, r.port);

   // ***************************************************************
   // Cycle sequencer
   // ***************************************************************
   always_comb begin
      next_r            = r;
      next_r.ack_sync   = {r.ack_sync[0], transfer_acknowledge_n_in};
      next_r.grant_sync = {r.grant_sync[0], bus_grant_in};
      next_r.ts_sync    = {r.ts_sync[0], transfer_start_strobe_n_in};
      next_r.as_sync    = {r.as_sync[0], address_strobe_n_in};
      next_r.din_sync1  = data_in;
      next_r.din_sync2  = r.din_sync1;
      next_r.beat_done  = 1'b0;
      next_r.xfer_done  = 1'b0;
      next_r.ts_n       = 1'b1;
      next_r.other_busy = ~grant & (~r.ts_sync[1] | ~r.as_sync[1]);
      case (r.state)
         ebc_pkg::S_IDLE: begin
            // (RULE8) release pins when another master owns bus
            next_r.oe      = 1'b0;
            next_r.data_oe = 1'b0;
            next_r.ready   = grant;
            if (accept) begin
               next_r.state         = ebc_pkg::S_START;
               next_r.addr          = req_in.addr;
               next_r.tsize         = req_in.size;
               next_r.port          = req_in.port;
               next_r.write         = req_in.write;
               next_r.burst_inhibit = req_in.burst_inhibit;
               next_r.rem           = req_bytes;
               next_r.beat          = launch_beat;
               next_r.misal         = (req_in.addr[3:0] &
                  (req_bytes[3:0] - 4'h1)) != 4'h0;
               next_r.first         = 1'b1;
               // (RULE1) misaligned beats show their own size
               if (next_r.misal) begin
                  next_r.siz = code_of(launch_beat);
               end else begin
                  // (RULE6) first access shows whole size
                  next_r.siz = req_in.size;
               end
               // (RULE7) start strobe on first valid clock
               next_r.ts_n    = 1'b0;
               next_r.oe      = 1'b1;
               next_r.data_oe = req_in.write;
               next_r.wdata   = wdata_in;
               next_r.ready   = 1'b0;
            end
         end
         ebc_pkg::S_START: begin
            // (RULE7) negate start strobe next clock
            next_r.state = ebc_pkg::S_WAIT;
         end
         ebc_pkg::S_WAIT: begin
            // (RULE11) hold the cycle until acknowledge
            if (ack_seen) begin
               next_r.rdata     = r.din_sync2;
               next_r.beat_done = 1'b1;
               next_r.rem       = r.rem - r.beat;
               next_r.first     = 1'b0;
               // (RULE12) keep write data one more clock
               next_r.state     = ebc_pkg::S_HOLD;
            end
         end
         ebc_pkg::S_HOLD: begin
            next_r.data_oe = 1'b0;
            if (r.rem == 5'h00) begin
               next_r.state     = ebc_pkg::S_IDLE;
               next_r.xfer_done = 1'b1;
               next_r.oe        = 1'b0;
               next_r.ready     = grant;
            end else begin
               next_r.state   = ebc_pkg::S_START;
               next_r.addr    = next_addr;
               next_r.beat    = cont_beat;
               next_r.ts_n    = 1'b0;
               next_r.data_oe = r.write;
               next_r.wdata   = wdata_in;
               // (RULE3) burst keeps the transfer size
               if (!r.burst_inhibit && !r.misal) begin
                  next_r.siz = r.tsize;
               end else begin
                  // (RULE4) (RULE5) port size after first
                  next_r.siz = code_of(cont_beat);
               end
            end
         end
         default: begin
            next_r.state = ebc_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         r.state         <= ebc_pkg::S_IDLE;
         r.addr          <= `EBC_RST_ADDR;
         r.rem           <= 5'h00;
         r.beat          <= 5'h00;
         r.tsize         <= `EBC_SIZ_LONG;
         r.port          <= `EBC_SIZ_LONG;
         r.write         <= 1'b0;
         r.burst_inhibit <= 1'b0;
         r.misal         <= 1'b0;
         r.first         <= 1'b0;
         r.siz           <= `EBC_SIZ_LONG;
         r.ts_n          <= `EBC_RST_STROBE;
         r.oe            <= `EBC_RST_OE;
         r.data_oe       <= `EBC_RST_OE;
         r.wdata         <= `EBC_RST_DATA;
         r.rdata         <= `EBC_RST_DATA;
         r.beat_done     <= 1'b0;
         r.xfer_done     <= 1'b0;
         r.ready         <= 1'b0;
         r.other_busy    <= 1'b0;
         r.ack_sync      <= 2'h3;
         r.grant_sync    <= 2'h0;
         r.ts_sync       <= 2'h3;
         r.as_sync       <= 2'h3;
         r.din_sync1     <= `EBC_RST_DATA;
         r.din_sync2     <= `EBC_RST_DATA;
      end else if (ce_in) begin
         r <= next_r;
      end
   end

   // ***************************************************************
   // Falling-edge address strobe
   // ***************************************************************
   // (RULE9) strobe covers start and wait clocks
   ebc_as_stage u_as_stage (
      .clock_in  (clock_in),
      .reset_in  (reset_in),
      .ce_in     (ce_in),
      .as_req_in (as_req),
      .own_in    (r.oe),
      .as_n_out  (address_strobe_n_out),
      .as_oe_out (address_strobe_oe_out)
   );

   assign req_ready_out                = r.ready;
   assign rdata_out                    = r.rdata;
   assign beat_done_out                = r.beat_done;
   assign xfer_done_out                = r.xfer_done;
   assign other_busy_out               = r.other_busy;
   assign addr_out                     = r.addr;
   assign beat_width_code_out          = r.siz;
   assign write_out                    = r.write;
   assign addr_oe_out                  = r.oe;
   assign data_out                     = r.wdata;
   assign data_oe_out                  = r.data_oe;
   assign transfer_start_strobe_n_out  = r.ts_n;
   assign transfer_start_strobe_oe_out = r.oe;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (reset_in || !ce_in);

   sequence s_launch;
      r.state == ebc_pkg::S_START;
   endsequence

   sequence s_write_ack;
      r.state == ebc_pkg::S_WAIT && ack_seen && r.write;
   endsequence

   a_ts_one_clock: assert property ( // RULE7
      !transfer_start_strobe_n_out |=> transfer_start_strobe_n_out)
      else $error("transfer start held longer than one clock");

   a_ts_with_attrs: assert property ( // RULE7
      !transfer_start_strobe_n_out |-> s_launch ##0 addr_oe_out)
      else $error("transfer start without valid address");

   a_misal_sizes: assert property ( // RULE1
      s_launch ##0 (r.misal && r.addr[1:0] == 2'h2 && r.rem == 5'h03 &&
                    r.tsize == `EBC_SIZ_LONG && r.port == `EBC_SIZ_LONG)
      |-> beat_width_code_out == `EBC_SIZ_WORD)
      else $error("misaligned middle beat is not a word");

   a_first_size: assert property ( // RULE6
      s_launch ##0 (r.first && !r.misal) |-> r.siz == r.tsize)
      else $error("first access does not show transfer size");

   a_burst_size: assert property ( // RULE3
      s_launch ##0 (!r.burst_inhibit && !r.misal) |-> r.siz == r.tsize)
      else $error("burst beat does not keep transfer size");

   a_inhibit_size: assert property ( // RULE4
      s_launch ##0 (!r.first && r.burst_inhibit) |->
      r.siz == code_of(r.beat))
      else $error("inhibited beat does not show port size");

   a_addr_stable: assert property ( // RULE9
      (r.state == ebc_pkg::S_WAIT || r.state == ebc_pkg::S_HOLD) |->
      $stable(addr_out) && $stable(beat_width_code_out))
      else $error("address changed while strobe asserted");

   a_wait_for_ack: assert property ( // RULE11
      r.state == ebc_pkg::S_WAIT && !ack_seen |=>
      r.state == ebc_pkg::S_WAIT)
      else $error("cycle ended without acknowledge");

   a_wdata_after_ack: assert property ( // RULE12
      s_write_ack |=> data_oe_out && $stable(data_out))
      else $error("write data not held after acknowledge");

   a_release_pins: assert property ( // RULE8
      r.state == ebc_pkg::S_IDLE && !grant |=>
      !transfer_start_strobe_oe_out)
      else $error("start strobe driven without ownership");

endmodule

/* File: verif/ebc_bus_partner.sv */
`timescale 1ns/10ps

// ***************************************************************
// Memory or peripheral on the far side of the bus
// ***************************************************************
module ebc_bus_partner (
   input  wire logic        clock_in,  // Bus clock
   input  wire logic        ts_n_in,   // Start pin level
   input  wire logic        as_n_in,   // Strobe pin level
   input  wire logic        own_in,    // Device drives the bus
   input  wire logic        write_in,  // Cycle direction
   input  wire logic [31:0] addr_in,   // Address pins
   input  wire logic [1:0]  delay_in,  // Wait states before ack
   output logic             ack_n_out, // Acknowledge pin
   output logic [31:0]      data_out   // Read data pins
);
   logic [1:0]  wait_cnt;
   logic        busy;
   logic        drive;
   logic [31:0] last;

   initial begin
      busy = 1'h0;
      drive = 1'h0;
      last = 32'h0;
      wait_cnt = 2'h0;
      ack_n_out = 1'h1;
   end

   // Read data held until strobe ends
   assign data_out = drive ? last : ~last;

   // One ack per cycle, never tied low
   always @(posedge clock_in) begin
      ack_n_out <= 1'h1;
      if (own_in && ts_n_in === 1'h0) begin
         busy <= 1'h1;
         wait_cnt <= delay_in;
         drive <= !write_in;
         last <= {addr_in[15:0], ~addr_in[15:0]};
      end else if (busy) begin
         if (wait_cnt == 2'h0) begin
            ack_n_out <= 1'h0;
            busy <= 1'h0;
         end else begin
            wait_cnt <= wait_cnt - 2'h1;
         end
      end else if (as_n_in === 1'h1) begin
         drive <= 1'h0;
      end
   end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
   typedef struct packed {
      logic [31:0] addr;
      logic [1:0]  sz;
      logic        w;
      logic [31:0] d;
   } ebc_tb_beat_t;

   logic              clock_in = 1'h0;
   logic              reset_in = 1'h1;
   logic              req_valid_in = 1'h0;
   ebc_pkg::ebc_req_t req_in = '0;
   logic [31:0]       wdata_in = 32'h0;
   logic              bus_grant_in = 1'h1;
   logic              ts_ext = 1'h1;
   logic [1:0]        delay = 2'h0;
   logic              ack_n;
   logic [31:0]       pdata;
   logic              req_ready_out, beat_done_out, xfer_done_out;
   logic              other_busy_out, write_out, addr_oe_out, data_oe_out;
   logic [31:0]       rdata_out, addr_out, data_out;
   logic [1:0]        beat_width_code_out;
   logic              ts_n_out, ts_oe_out, as_n_out, as_oe_out;
   logic              ts_pin, as_pin, ts_seen;
   ebc_tb_beat_t      exp_q[$];
   ebc_tb_beat_t      cur;
   logic [31:0]       seed = 32'h9f8c;
   logic [11:0]       scen [9];
   int                n_fail = 0;
   int                tests_run = 0;
   int                cyc = 0;
   int                n_done = 0;
   int                n_xfer = 0;

   assign ts_pin = ts_oe_out ? ts_n_out : ts_ext;
   assign as_pin = as_oe_out ? as_n_out : 1'h1;

   always #20 clock_in = ~clock_in;

   ebc_bus_master dut_u (
      .clock_in(clock_in), .reset_in(reset_in), .ce_in(1'h1),
      .req_valid_in(req_valid_in), .req_in(req_in), .wdata_in(wdata_in),
      .req_ready_out(req_ready_out), .rdata_out(rdata_out),
      .beat_done_out(beat_done_out), .xfer_done_out(xfer_done_out),
      .other_busy_out(other_busy_out), .bus_grant_in(bus_grant_in),
      .transfer_acknowledge_n_in(ack_n), .addr_out(addr_out),
      .beat_width_code_out(beat_width_code_out), .write_out(write_out),
      .addr_oe_out(addr_oe_out), .data_out(data_out),
      .data_oe_out(data_oe_out), .data_in(pdata),
      .transfer_start_strobe_n_out(ts_n_out),
      .transfer_start_strobe_oe_out(ts_oe_out),
      .transfer_start_strobe_n_in(ts_pin),
      .address_strobe_n_out(as_n_out), .address_strobe_oe_out(as_oe_out),
      .address_strobe_n_in(as_pin));

   ebc_bus_partner partner_u (
      .clock_in(clock_in), .ts_n_in(ts_pin), .as_n_in(as_pin),
      .own_in(addr_oe_out), .write_in(write_out), .addr_in(addr_out),
      .delay_in(delay), .ack_n_out(ack_n), .data_out(pdata));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [4:0] nbytes(input logic [1:0] c);
      nbytes = (c == 2'h0) ? 5'h04 : (c == 2'h1) ? 5'h01 :
               (c == 2'h2) ? 5'h02 : 5'h10;
   endfunction

   function automatic logic [1:0] code_of(input logic [4:0] n);
      code_of = (n == 5'h01) ? 2'h1 : (n == 5'h02) ? 2'h2 :
                (n == 5'h04) ? 2'h0 : 2'h3;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic close_out;
      $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ***************************************************************
   // Driver: notes expected beats, then issues the request
   // ***************************************************************
   task automatic run_xfer(input logic [31:0] a, input logic [1:0] sz,
                           input logic [1:0] pt, input logic inh,
                           input logic wr);
      logic [31:0] d[$];
      logic [31:0] ad;
      logic [4:0]  rem;
      logic [4:0]  n;
      logic        first;
      logic        mis;
      int          k;
      ad = a;
      rem = nbytes(sz);
      mis = (a[4:0] & (rem - 5'h01)) != 5'h00;
      first = 1'h1;
      while (rem != 5'h00) begin
         n = nbytes((pt == 2'h3) ? 2'h0 : pt);
         while ((ad[4:0] & (n - 5'h01)) != 5'h00) n = n >> 1;
         if (n > rem) n = (rem >= 5'h02) ? 5'h02 : 5'h01;
         seed = lfsr(seed);
         d.push_back(seed);
         exp_q.push_back('{ad, (!mis && (first || !inh)) ? sz : code_of(n),
                           wr, seed});
         ad = ad + {27'h0, n};
         rem = rem - n;
         first = 1'h0;
      end
      k = 0;
      while (req_ready_out !== 1'h1 && k < 100) begin
         @(negedge clock_in);
         k++;
      end
      check(req_ready_out, 1'h1);
      req_in = '{a, sz, pt, wr, inh};
      wdata_in = d.pop_front();
      req_valid_in = 1'h1;
      @(negedge clock_in);
      req_valid_in = 1'h0;
      k = 0;
      while (xfer_done_out !== 1'h1 && k < 300) begin
         if (beat_done_out === 1'h1 && d.size() > 0) wdata_in = d.pop_front();
         @(negedge clock_in);
         k++;
      end
      check(xfer_done_out, 1'h1);
   endtask

   // ***************************************************************
   // Monitor: takes the oldest note at each start and compares
   // ***************************************************************
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
      if (xfer_done_out === 1'h1) n_done++;
      if (ts_seen === 1'h1) begin
         check(ts_n_out, 1'h1);
         check(as_n_out, 1'h0);
         check(addr_out, cur.addr);
      end
      ts_seen <= 1'h0;
      if (!reset_in && ts_oe_out === 1'h1 && ts_n_out === 1'h0) begin
         if (exp_q.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            cur = exp_q.pop_front();
            check(addr_out, cur.addr);
            check(beat_width_code_out, cur.sz);
            check(write_out, cur.w);
            ts_seen <= 1'h1;
         end
      end
      if (beat_done_out === 1'h1) begin
         if (cur.w) begin
            check(data_oe_out, 1'h1);
            check(data_out, cur.d);
         end else begin
            check(rdata_out, {cur.addr[15:0], ~cur.addr[15:0]});
         end
      end
   end

   // Strobe moves only while the clock is low
   always @(as_n_out) begin
      if (!reset_in) check(clock_in, 1'h0);
   end

   initial begin
      int k;
      scen = '{12'h004, 12'h105, 12'h102, 12'h014, 12'h01f,
               12'h0c1, 12'h0c8, 12'h09e, 12'h050};
      repeat (10) @(negedge clock_in);
      reset_in = 1'h0;
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            delay = scen[i][1:0];
            run_xfer({seed[31:4], scen[i][11:8]}, scen[i][7:6], scen[i][5:4],
                     scen[i][3], scen[i][2]);
            n_xfer++;
         end
      end
      repeat (4) @(negedge clock_in);
      check(n_done, n_xfer);
      check(exp_q.size(), 0);
      bus_grant_in = 1'h0;
      repeat (5) @(negedge clock_in);
      check(ts_oe_out, 1'h0);
      check(as_oe_out, 1'h0);
      check(addr_oe_out, 1'h0);
      check(req_ready_out, 1'h0);
      ts_ext = 1'h0;
      @(negedge clock_in);
      ts_ext = 1'h1;
      k = 0;
      while (other_busy_out !== 1'h1 && k < 6) begin
         @(negedge clock_in);
         k++;
      end
      check(other_busy_out, 1'h1);
      close_out();
   end
endmodule
